// ### hw/mmfcs_pkg.sv
package mmfcs_pkg;

	// RL23 mode encoding
	// access modes, lower is more privileged
	typedef enum logic [1:0] {
		MODE_KERNEL = 2'h0,
		MODE_EXEC = 2'h1,
		MODE_SUPER = 2'h2,
		MODE_USER = 2'h3
	} mmfcs_mode_t;

	typedef enum logic [2:0] {
		FC_NONE = 3'h0,
		FC_ACCESS_VIOL = 3'h1,
		FC_INVALID_XLAT = 3'h2,
		FC_READ_TRAP = 3'h3,
		FC_WRITE_TRAP = 3'h4,
		FC_FETCH_TRAP = 3'h5
	} mmfcs_fcode_t;

	// dispatch vector offsets
	localparam logic [15:0] VEC_ACCESS_VIOL = 16'h0080;
	localparam logic [15:0] VEC_INVALID_XLAT = 16'h0090;
	localparam logic [15:0] VEC_READ_TRAP = 16'h00A0;
	localparam logic [15:0] VEC_WRITE_TRAP = 16'h00B0;
	localparam logic [15:0] VEC_FETCH_TRAP = 16'h00C0;

	typedef struct packed {
		logic v;
		logic kernel_read_permit;
	} mmfcs_upper_pte_t;

	typedef struct packed {
		logic v;
		logic [3:0] rd_en;
		logic [3:0] wr_en;
		logic read_trap;
		logic write_trap;
		logic fetch_trap;
	} mmfcs_leaf_pte_t;

	typedef struct packed {
		logic valid;
		logic rd;
		logic wr;
		logic ex;
		mmfcs_mode_t mode;
		mmfcs_upper_pte_t l1;
		mmfcs_upper_pte_t l2;
		mmfcs_leaf_pte_t l3;
	} mmfcs_access_t;

	typedef struct packed {
		logic valid;
		mmfcs_fcode_t code;
		logic [15:0] vector;
	} mmfcs_fault_t;

	// context block layout
	localparam int CTX_BYTES = 128;
	localparam int CTX_WORDS = 16;
	localparam logic [3:0] IDX_ROOT = 4'h4;
	localparam logic [3:0] IDX_TAG = 4'h5;
	localparam logic [3:0] IDX_TRAPS = 4'h6;
	localparam logic [3:0] IDX_FLAGS = 4'h7;
	localparam int BIT_FEN = 0;
	localparam int BIT_QUIET = 1;
	localparam int BIT_PERF = 63;
	localparam int TRAP_EN_LSB = 0;
	localparam int TRAP_PEND_LSB = 4;
	localparam logic [4:0] TRAP_LEVEL = 5'h02;
	localparam logic [3:0] MASK_RESET = 4'h0;

endpackage : mmfcs_pkg

// ### hw/mmfcs_fault_class.sv
`timescale 1ns/1ps
`default_nettype none
module mmfcs_fault_class (
	// access under test
	input wire mmfcs_pkg::mmfcs_access_t acc,
	// chosen fault
	output mmfcs_pkg::mmfcs_fault_t fault
);
	logic upper_acv;
	logic upper_tnv;
	logic prot_acv;
	logic is_ref;
	always_comb begin
		is_ref = acc.rd | acc.wr | acc.ex;
		// RL2 invalid upper kre
		upper_acv = (!acc.l1.v && !acc.l1.kernel_read_permit) ||
			(acc.l1.v && !acc.l2.v && !acc.l2.kernel_read_permit);
		// RL6 invalid first or second level entry with kre set; leaf checked below
		upper_tnv = (!acc.l1.v && acc.l1.kernel_read_permit) ||
			(acc.l1.v && !acc.l2.v && acc.l2.kernel_read_permit);
		// RL1 leaf protection
		prot_acv = ((acc.rd | acc.ex) && !acc.l3.rd_en[acc.mode]) ||
			(acc.wr && !acc.l3.wr_en[acc.mode]);
		fault.valid = 1'b0;
		fault.code = mmfcs_pkg::FC_NONE;
		fault.vector = 16'h0000;
		// RL24 single code by precedence
		if (!acc.valid || !is_ref) begin
			fault.code = mmfcs_pkg::FC_NONE;
		// RL8 violation first, except a leaf protection violation under an invalid upper entry with kre set
		end else if (upper_acv || (!upper_tnv && prot_acv)) begin
			fault.code = mmfcs_pkg::FC_ACCESS_VIOL;
		// RL9 invalid before traps
		end else if (upper_tnv || !acc.l3.v) begin
			fault.code = mmfcs_pkg::FC_INVALID_XLAT;
		// RL3 read trap; RL10 taken before write trap
		end else if ((acc.rd | acc.ex) && acc.l3.read_trap) begin
			fault.code = mmfcs_pkg::FC_READ_TRAP;
		// RL4 write trap
		end else if (acc.wr && acc.l3.write_trap) begin
			fault.code = mmfcs_pkg::FC_WRITE_TRAP;
		// RL5 fetch trap
		end else if (acc.ex && acc.l3.fetch_trap) begin
			fault.code = mmfcs_pkg::FC_FETCH_TRAP;
		end
		// RL7 distinct vectors
		case (fault.code)
			mmfcs_pkg::FC_ACCESS_VIOL: fault.vector = mmfcs_pkg::VEC_ACCESS_VIOL;
			mmfcs_pkg::FC_INVALID_XLAT: fault.vector = mmfcs_pkg::VEC_INVALID_XLAT;
			mmfcs_pkg::FC_READ_TRAP: fault.vector = mmfcs_pkg::VEC_READ_TRAP;
			mmfcs_pkg::FC_WRITE_TRAP: fault.vector = mmfcs_pkg::VEC_WRITE_TRAP;
			mmfcs_pkg::FC_FETCH_TRAP: fault.vector = mmfcs_pkg::VEC_FETCH_TRAP;
			default: fault.vector = 16'h0000;
		endcase
		fault.valid = (fault.code != mmfcs_pkg::FC_NONE);
	end
endmodule : mmfcs_fault_class
`default_nettype wire

// ### hw/mmfcs_trap_eval.sv
`timescale 1ns/1ps
`default_nettype none
module mmfcs_trap_eval (
	// trap state
	input wire logic [3:0] enable_mask,
	input wire logic [3:0] pending_mask,
	input wire mmfcs_pkg::mmfcs_mode_t mode,
	input wire logic [4:0] level,
	// decision
	output logic take,
	output logic [1:0] take_mode
);
	logic [3:0] elig;
	always_comb begin
		// RL22 modes at or above current privilege
		for (int i = 0; i < 4; i++) begin
			elig[i] = pending_mask[i] && enable_mask[i] && (2'(i) <= mode);
		end
		take = (level < mmfcs_pkg::TRAP_LEVEL) && (elig != 4'h0);
		take_mode = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (elig[i]) begin
				take_mode = 2'(i);
			end
		end
	end
endmodule : mmfcs_trap_eval
`default_nettype wire

// ### hw/mmfcs_unit.sv
// Behaviour
// RL1 - leaf entry protection forbidding access in current mode gives access violation
// RL2 - invalid first or second level entry with kernel read permit clear: violation
// RL3 - read through entry with read trap bit gives read trap fault
// RL4 - write through entry with write trap bit gives write trap fault
// RL5 - execution from page with fetch trap bit gives fetch trap fault
// RL6 - read or write through invalid entry at any level: invalid translation
// RL7 - each of five fault types has its own dispatch vector
// RL8 - access violation hides all other coincident faults; code lets invalid upper entry with kre set hide leaf protection violation
// RL9 - invalid translation reported before any read, write or fetch trap
// RL10 - read and write traps together may be taken in either order
// RL11 - idle process context lives in an aligned 128-byte block
// RL12 - swap saves context at old base, loads new base, loads new context
// RL13 - software supplies aligned base covering sixteen quadwords of memory
// RL14 - software keeps page table root naming an existing memory frame
// RL15 - software never writes a block the processor owns
// RL16 - device may update owned block fields, each decided independently
// RL17 - without space tags the swap never touches the tag field
// RL18 - block float enable bit tracks the float enable register
// RL19 - quiet bit clear reports fixed alignment traps, set returns to user
// RL20 - trap enable mask has one enable bit per access mode
// RL21 - trap pending mask has one pending bit per access mode
// RL22 - level below 2 and eligible pending enabled trap starts trap at 2
// RL23 - mode encodes kernel 0, executive 1, supervisor 2, user 3
// RL24 - several faults give one code chosen by fixed precedence
`timescale 1ns/1ps
`default_nettype none
module mmfcs_unit #(
	parameter int PA_W = 48,
	parameter bit SPACE_TAG_EN = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// translation access
	input wire mmfcs_pkg::mmfcs_access_t acc,
	output mmfcs_pkg::mmfcs_fault_t fault_q,
	// processor state
	input wire mmfcs_pkg::mmfcs_mode_t current_mode,
	input wire logic [4:0] priority_level,
	// trap mask writes
	input wire logic enable_we,
	input wire logic [3:0] enable_wdata,
	input wire logic pending_we,
	input wire logic [3:0] pending_wdata,
	input wire logic pending_clr,
	input wire logic [3:0] pending_clr_mask,
	output logic [3:0] trap_enable_mask,
	output logic [3:0] trap_pending_mask,
	// trap request
	output logic trap_take,
	output logic [1:0] trap_take_mode,
	output logic [4:0] trap_take_level,
	// float enable register
	input wire logic fen_we,
	input wire logic fen_wdata,
	output logic float_unit_enable,
	// alignment fixup
	input wire logic align_fixed,
	output logic align_report_q,
	output logic align_return_q,
	// live context field update
	input wire logic ctx_we,
	input wire logic [3:0] ctx_widx,
	input wire logic [63:0] ctx_wdata,
	// context readback
	output logic [63:0] page_table_root,
	output logic [63:0] space_tag,
	output logic perf_watch_bit,
	output logic align_trap_quiet,
	output logic [PA_W-1:0] context_block_base,
	// swap request
	input wire logic swap_req,
	input wire logic [PA_W-1:0] swap_new_base,
	output logic swap_busy,
	output logic swap_done_q,
	// context memory
	output logic mem_req,
	output logic mem_we,
	output logic [PA_W-1:0] mem_addr_q,
	output logic [63:0] mem_wdata_q,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SAVE = 5'b00010,
		ST_BASE = 5'b00100,
		ST_LOAD = 5'b01000,
		ST_DONE = 5'b10000
	} mmfcs_state_t;

	mmfcs_state_t state_q;
	mmfcs_pkg::mmfcs_fault_t fault_d;
	logic [63:0] ctx_q [mmfcs_pkg::CTX_WORDS];
	logic [3:0] idx_q;
	logic [PA_W-1:0] base_q;
	logic [PA_W-1:0] new_base_q;
	logic [3:0] en_q;
	logic [3:0] pend_q;
	logic fen_q;
	logic last_idx;
	logic [3:0] next_idx;
	logic [63:0] save_word;
	logic [63:0] flags_word;
	logic word_ack;

	// fault classification
	mmfcs_fault_class u_class (
		.acc(acc),
		.fault(fault_d)
	);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fault_q <= '0;
		end else begin
			fault_q <= fault_d;
		end
	end

	// trap evaluation
	mmfcs_trap_eval u_trap (
		.enable_mask(en_q),
		.pending_mask(pend_q),
		.mode(current_mode),
		.level(priority_level),
		.take(trap_take),
		.take_mode(trap_take_mode)
	);
	assign trap_take_level = mmfcs_pkg::TRAP_LEVEL;

	assign word_ack = mem_req && mem_ack;

	// next field, tag skipped when absent
	always_comb begin
		next_idx = idx_q + 4'h1;
		if (!SPACE_TAG_EN && next_idx == mmfcs_pkg::IDX_TAG) begin
			next_idx = next_idx + 4'h1;
		end
		last_idx = (idx_q == 4'(mmfcs_pkg::CTX_WORDS - 1));
	end

	// RL18 live float enable into block
	always_comb begin
		flags_word = ctx_q[mmfcs_pkg::IDX_FLAGS];
		flags_word[mmfcs_pkg::BIT_FEN] = fen_q;
		save_word = ctx_q[idx_q];
		case (idx_q)
			mmfcs_pkg::IDX_TRAPS: begin
				save_word = 64'h0;
				save_word[mmfcs_pkg::TRAP_EN_LSB +: 4] = en_q;
				save_word[mmfcs_pkg::TRAP_PEND_LSB +: 4] = pend_q;
			end
			mmfcs_pkg::IDX_FLAGS: save_word = flags_word;
			default: save_word = ctx_q[idx_q];
		endcase
	end

	// RL12 swap sequence
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			idx_q <= 4'h0;
			new_base_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (swap_req) begin
						state_q <= ST_SAVE;
						idx_q <= 4'h0;
						new_base_q <= swap_new_base;
					end
				end
				ST_SAVE: begin
					if (word_ack) begin
						idx_q <= next_idx;
						if (last_idx) begin
							state_q <= ST_BASE;
						end
					end
				end
				ST_BASE: begin
					state_q <= ST_LOAD;
					idx_q <= 4'h0;
				end
				ST_LOAD: begin
					if (word_ack) begin
						idx_q <= next_idx;
						if (last_idx) begin
							state_q <= ST_DONE;
						end
					end
				end
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// RL11 base register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			base_q <= '0;
		end else if (state_q == ST_BASE) begin
			base_q <= new_base_q;
		end
	end

	// RL13 base assumed aligned by software
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mem_addr_q <= '0;
			mem_wdata_q <= 64'h0;
		end else begin
			mem_addr_q <= base_q + PA_W'({idx_q, 3'h0});
			mem_wdata_q <= save_word;
			// address lags ack a cycle, so request drops between words
			if (state_q == ST_BASE) begin
				mem_addr_q <= new_base_q;
			end
		end
	end

	// RL17 tag never requested when absent
	assign mem_req = (state_q == ST_SAVE || state_q == ST_LOAD) &&
		mem_addr_q == base_q + PA_W'({idx_q, 3'h0});
	assign mem_we = (state_q == ST_SAVE);

	// RL16 fields updated individually
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < mmfcs_pkg::CTX_WORDS; i++) begin
				ctx_q[i] <= 64'h0;
			end
		end else if (state_q == ST_LOAD && word_ack) begin
			ctx_q[idx_q] <= mem_rdata;
		end else if (ctx_we && state_q == ST_IDLE) begin
			ctx_q[ctx_widx] <= ctx_wdata;
		end
	end

	// RL20 enable mask
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_q <= mmfcs_pkg::MASK_RESET;
		end else if (state_q == ST_LOAD && word_ack && idx_q == mmfcs_pkg::IDX_TRAPS) begin
			en_q <= mem_rdata[mmfcs_pkg::TRAP_EN_LSB +: 4];
		end else if (enable_we) begin
			en_q <= enable_wdata;
		end
	end

	// RL21 pending mask, set wins over clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pend_q <= mmfcs_pkg::MASK_RESET;
		end else if (state_q == ST_LOAD && word_ack && idx_q == mmfcs_pkg::IDX_TRAPS) begin
			pend_q <= mem_rdata[mmfcs_pkg::TRAP_PEND_LSB +: 4];
		end else begin
			pend_q <= (pend_q & ~({4{pending_clr}} & pending_clr_mask)) |
				({4{pending_we}} & pending_wdata);
		end
	end

	// RL18 float enable register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fen_q <= 1'b0;
		end else if (state_q == ST_LOAD && word_ack && idx_q == mmfcs_pkg::IDX_FLAGS) begin
			fen_q <= mem_rdata[mmfcs_pkg::BIT_FEN];
		end else if (fen_we) begin
			fen_q <= fen_wdata;
		end
	end

	// RL19 alignment fixup outcome
	always_ff @(posedge clk) begin
		if (!rstn) begin
			align_report_q <= 1'b0;
			align_return_q <= 1'b0;
		end else begin
			align_report_q <= align_fixed && !align_trap_quiet;
			align_return_q <= align_fixed && align_trap_quiet;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			swap_done_q <= 1'b0;
		end else begin
			swap_done_q <= (state_q == ST_DONE);
		end
	end

	assign swap_busy = (state_q != ST_IDLE);
	assign trap_enable_mask = en_q;
	assign trap_pending_mask = pend_q;
	assign float_unit_enable = fen_q;
	assign context_block_base = base_q;
	assign page_table_root = ctx_q[mmfcs_pkg::IDX_ROOT];
	assign space_tag = SPACE_TAG_EN ? ctx_q[mmfcs_pkg::IDX_TAG] : 64'h0;
	assign perf_watch_bit = ctx_q[mmfcs_pkg::IDX_FLAGS][mmfcs_pkg::BIT_PERF];
	assign align_trap_quiet = ctx_q[mmfcs_pkg::IDX_FLAGS][mmfcs_pkg::BIT_QUIET];

endmodule : mmfcs_unit
`default_nettype wire

// ### testbench/mmfcs_unit_props.sv
`timescale 1ns/1ps
`default_nettype none
module mmfcs_unit_props #(
	parameter int PA_W = 48
) (
	// watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire mmfcs_pkg::mmfcs_access_t acc,
	input wire mmfcs_pkg::mmfcs_fault_t fault_q,
	input wire mmfcs_pkg::mmfcs_mode_t current_mode,
	input wire logic [4:0] priority_level,
	input wire logic pending_we,
	input wire logic [3:0] pending_wdata,
	input wire logic [3:0] trap_enable_mask,
	input wire logic [3:0] trap_pending_mask,
	input wire logic trap_take,
	input wire logic [1:0] trap_take_mode,
	input wire logic [4:0] trap_take_level,
	input wire logic align_fixed,
	input wire logic align_report_q,
	input wire logic align_return_q,
	input wire logic align_trap_quiet,
	input wire logic swap_req,
	input wire logic swap_busy,
	input wire logic swap_done_q,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [PA_W-1:0] mem_addr_q,
	input wire logic [PA_W-1:0] context_block_base
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// plain read with both upper levels valid
	wire logic rq = acc.valid && acc.rd && !acc.wr && !acc.ex && acc.l1.v && acc.l2.v;
	property p_up;
		acc.valid && acc.rd && !acc.l1.v && !acc.l1.kernel_read_permit |=> fault_q.code == 3'h1;
	endproperty
	a_up: assert property (p_up) else $error("upper violation missed");
	property p_prot;
		rq && !acc.l3.rd_en[acc.mode] |=> fault_q.code == 3'h1;
	endproperty
	a_prot: assert property (p_prot) else $error("leaf violation missed");
	property p_inv;
		rq && !acc.l3.v && acc.l3.rd_en[acc.mode] |=> fault_q.code == 3'h2;
	endproperty
	a_inv: assert property (p_inv) else $error("invalid leaf missed");
	property p_rtrap;
		rq && acc.l3.v && acc.l3.rd_en[acc.mode] && acc.l3.read_trap |=> fault_q.code == 3'h3;
	endproperty
	a_rtrap: assert property (p_rtrap) else $error("read trap missed");
	property p_vec;
		fault_q.valid |-> fault_q.vector == 16'h0070 + {9'h000, fault_q.code, 4'h0};
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector");
	property p_take;
		trap_take |-> priority_level < 5'h02 && trap_take_level == 5'h02
			&& trap_enable_mask[trap_take_mode] && trap_pending_mask[trap_take_mode]
			&& trap_take_mode <= current_mode;
	endproperty
	a_take: assert property (p_take) else $error("bad trap take");
	property p_must;
		(trap_enable_mask & trap_pending_mask) != 4'h0 && priority_level == 5'h00
			&& current_mode == mmfcs_pkg::MODE_USER |-> trap_take;
	endproperty
	a_must: assert property (p_must) else $error("trap not taken");
	property p_pend;
		pending_we |=> (trap_pending_mask & $past(pending_wdata)) == $past(pending_wdata);
	endproperty
	a_pend: assert property (p_pend) else $error("pending bit lost");
	property p_align;
		align_fixed |=> align_report_q != $past(align_trap_quiet)
			&& align_return_q == $past(align_trap_quiet);
	endproperty
	a_align: assert property (p_align) else $error("bad alignment outcome");
	property p_save;
		swap_req && !swap_busy |=> mem_req && mem_we && mem_addr_q == $past(context_block_base);
	endproperty
	a_save: assert property (p_save) else $error("swap not saving at old base");
	property p_done;
		swap_req && !swap_busy |-> ##[1:400] swap_done_q;
	endproperty
	a_done: assert property (p_done) else $error("swap never done");
endmodule : mmfcs_unit_props
bind mmfcs_unit mmfcs_unit_props #(.PA_W(PA_W)) mmfcs_unit_props_i (.clk, .rstn, .acc,
	.fault_q, .current_mode, .priority_level, .pending_we, .pending_wdata, .trap_enable_mask,
	.trap_pending_mask, .trap_take, .trap_take_mode, .trap_take_level, .align_fixed,
	.align_report_q, .align_return_q, .align_trap_quiet, .swap_req, .swap_busy, .swap_done_q,
	.mem_req, .mem_we, .mem_addr_q, .context_block_base);
`default_nettype wire

// ### testbench/mmfcs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmfcs_mem_model (
	// clock and pacing
	input wire logic clk,
	input wire logic [1:0] slow,
	// context memory
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [47:0] mem_addr_q,
	input wire logic [63:0] mem_wdata_q,
	output logic mem_ack,
	output logic [63:0] mem_rdata
);
	logic [63:0] mem [32];
	logic [1:0] wait_q;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 64'h0;
		wait_q = 2'h0;
	end
	// two aligned blocks of sixteen quadwords
	// owned block never written from outside
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_q != slow) begin
				wait_q <= wait_q + 2'h1;
			end else begin
				wait_q <= 2'h0;
				mem_ack <= 1'b1;
				if (mem_we) mem[mem_addr_q[7:3]] <= mem_wdata_q;
				else mem_rdata <= mem[mem_addr_q[7:3]];
			end
		end
	end
endmodule : mmfcs_mem_model
`default_nettype wire

// ### testbench/tb_mmfcs_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mmfcs_unit;
	logic clk, rstn, enable_we, pending_we, pending_clr, fen_we, fen_wdata, float_unit_enable;
	logic trap_take, align_fixed, align_report_q, align_return_q, ctx_we, perf_watch_bit;
	logic align_trap_quiet, swap_req, swap_busy, swap_done_q, mem_req, mem_we, mem_ack;
	mmfcs_pkg::mmfcs_access_t acc;
	mmfcs_pkg::mmfcs_fault_t fault_q;
	mmfcs_pkg::mmfcs_mode_t current_mode;
	logic [4:0] priority_level, trap_take_level;
	logic [3:0] enable_wdata, pending_wdata, pending_clr_mask, trap_enable_mask;
	logic [3:0] trap_pending_mask, ctx_widx;
	logic [1:0] trap_take_mode, slow;
	logic [63:0] ctx_wdata, page_table_root, space_tag, mem_wdata_q, mem_rdata, root;
	logic [47:0] context_block_base, swap_new_base, mem_addr_q;
	int fail_count, checks, n;
	mmfcs_unit mmfcs_unit_i (.clk, .rstn, .acc, .fault_q, .current_mode, .priority_level,
		.enable_we, .enable_wdata, .pending_we, .pending_wdata, .pending_clr, .pending_clr_mask,
		.trap_enable_mask, .trap_pending_mask, .trap_take, .trap_take_mode, .trap_take_level,
		.fen_we, .fen_wdata, .float_unit_enable, .align_fixed, .align_report_q, .align_return_q,
		.ctx_we, .ctx_widx, .ctx_wdata, .page_table_root, .space_tag, .perf_watch_bit,
		.align_trap_quiet, .context_block_base, .swap_req, .swap_new_base, .swap_busy,
		.swap_done_q, .mem_req, .mem_we, .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata);
	mmfcs_mem_model mmfcs_mem_model_i (.clk, .slow, .mem_req, .mem_we, .mem_addr_q,
		.mem_wdata_q, .mem_ack, .mem_rdata);
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %0h got %0h", nm, e, s);
		end
	endtask : cmp
	task automatic final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// access with rd/wr/ex, mode, upper entries {v,kre,v,kre}, leaf bits
	task automatic ft(input logic [2:0] rwx, input logic [1:0] m, input logic [3:0] up,
			input logic [11:0] lf, input logic [2:0] e);
		@(posedge clk);
		acc <= {1'b1, rwx, m, up, lf};
		@(posedge clk);
		#1;
		cmp("code", {61'h0, e}, {61'h0, fault_q.code});
		if (e != 3'h0) cmp("vector", 16'h0070 + {9'h000, e, 4'h0}, {48'h0, fault_q.vector});
	endtask : ft
	task automatic tp(input logic [1:0] m, input logic [4:0] l, input logic t,
			input logic [1:0] tm);
		@(posedge clk);
		current_mode <= mmfcs_pkg::mmfcs_mode_t'(m);
		priority_level <= l;
		@(posedge clk);
		#1;
		cmp("take", {63'h0, t}, {63'h0, trap_take});
		if (t) cmp("take_mode", {62'h0, tm}, {62'h0, trap_take_mode});
		if (t) cmp("take_level", 64'h2, {59'h0, trap_take_level});
	endtask : tp
	task automatic pulse(input logic [3:0] en, input logic [3:0] pd, input logic [3:0] cl);
		@(posedge clk);
		enable_we <= en != 4'h0;
		enable_wdata <= en;
		pending_we <= pd != 4'h0;
		pending_wdata <= pd;
		pending_clr <= cl != 4'h0;
		pending_clr_mask <= cl;
		@(posedge clk);
		{enable_we, pending_we, pending_clr} <= 3'h0;
	endtask : pulse
	task automatic algn(input logic rep);
		@(posedge clk);
		align_fixed <= 1'b1;
		@(posedge clk);
		align_fixed <= 1'b0;
		#1;
		cmp("report", {63'h0, rep}, {63'h0, align_report_q});
		cmp("return", {63'h0, !rep}, {63'h0, align_return_q});
	endtask : algn
	task automatic cw(input logic [3:0] i, input logic [63:0] d);
		@(posedge clk);
		ctx_we <= 1'b1;
		ctx_widx <= i;
		ctx_wdata <= d;
		@(posedge clk);
		ctx_we <= 1'b0;
	endtask : cw
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	initial begin
		{rstn, acc, priority_level, enable_we, enable_wdata, pending_we, pending_wdata} = '0;
		{pending_clr, pending_clr_mask, fen_we, fen_wdata, align_fixed, ctx_we} = '0;
		{ctx_widx, ctx_wdata, swap_req, swap_new_base, slow, fail_count, checks} = '0;
		current_mode = mmfcs_pkg::MODE_KERNEL;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		cmp("masks", 64'h0, {56'h0, trap_enable_mask, trap_pending_mask});
		cmp("base", 64'h0, {16'h0, context_block_base});
		ft(3'h4, 2'h3, 4'hF, 12'hFF8, 3'h0);
		ft(3'h4, 2'h3, 4'h3, 12'hFF8, 3'h1);
		ft(3'h4, 2'h3, 4'hC, 12'hFF8, 3'h1);
		ft(3'h4, 2'h3, 4'h7, 12'hFF8, 3'h2);
		ft(3'h4, 2'h3, 4'hF, 12'hBFC, 3'h1);
		ft(3'h2, 2'h3, 4'hF, 12'hFB8, 3'h1);
		ft(3'h4, 2'h0, 4'hF, 12'hF78, 3'h1);
		ft(3'h4, 2'h3, 4'hF, 12'hF78, 3'h0);
		ft(3'h4, 2'h3, 4'hF, 12'h7FC, 3'h2);
		ft(3'h4, 2'h3, 4'hF, 12'hFFC, 3'h3);
		ft(3'h2, 2'h3, 4'hF, 12'hFFA, 3'h4);
		ft(3'h1, 2'h3, 4'hF, 12'hFF9, 3'h5);
		ft(3'h6, 2'h3, 4'hF, 12'hFFE, 3'h3);
		ft(3'h0, 2'h3, 4'hF, 12'hFFE, 3'h0);
		pulse(4'h5, 4'h4, 4'h0);
		tp(2'h3, 5'h00, 1'b1, 2'h2);
		tp(2'h1, 5'h00, 1'b0, 2'h0);
		tp(2'h2, 5'h01, 1'b1, 2'h2);
		tp(2'h3, 5'h02, 1'b0, 2'h0);
		pulse(4'h0, 4'h1, 4'h4);
		#1;
		cmp("masks", 64'h51, {56'h0, trap_enable_mask, trap_pending_mask});
		tp(2'h1, 5'h00, 1'b1, 2'h0);
		pulse(4'h0, 4'h0, 4'h1);
		tp(2'h3, 5'h00, 1'b0, 2'h0);
		@(posedge clk);
		fen_we <= 1'b1;
		fen_wdata <= 1'b1;
		@(posedge clk);
		fen_we <= 1'b0;
		algn(1'b1);
		cw(4'h7, 64'h8000000000000002);
		cw(4'h4, 64'h1234);
		#1;
		cmp("flags", 64'h7, {61'h0, perf_watch_bit, align_trap_quiet, float_unit_enable});
		algn(1'b0);
		root = 64'h1234;
		for (int k = 0; k < 2; k++) begin
			// preloaded root names an existing frame
			for (int i = 0; i < 16; i++) mmfcs_mem_model_i.mem[16 * (1 - k) + i] = 64'h5A00 + i;
			@(posedge clk);
			slow <= 2'(k * 2);
			swap_new_base <= k == 0 ? 48'h80 : 48'h0;
			swap_req <= 1'b1;
			@(posedge clk);
			swap_req <= 1'b0;
			for (n = 0; n < 500 && swap_done_q !== 1'b1; n++) begin
				@(posedge clk);
				#1;
			end
			cmp("done", 64'h1, {63'h0, swap_done_q});
			cmp("base", k == 0 ? 64'h80 : 64'h0, {16'h0, context_block_base});
			cmp("saved_root", root, mmfcs_mem_model_i.mem[16 * k + 4]);
			cmp("saved_fen", 64'h1, {63'h0, mmfcs_mem_model_i.mem[16 * k + 7][0]});
			cmp("root", 64'h5A04, page_table_root);
			cmp("tag", 64'h5A05, space_tag);
			root = 64'h5A04;
		end
		final_report();
	end
endmodule : tb_mmfcs_unit
`default_nettype wire
